// ===== core/ssp_regs.vh
`ifndef SSP_REGS_VH
`define SSP_REGS_VH

// format field layout
`define SSP_FMT_W 4
`define SSP_FMT_FRAME_LSB 0
`define SSP_FMT_FRAME_MSB 1
`define SSP_FMT_REGMODE_BIT 2
`define SSP_FMT_DATA7_BIT 3

// framing codes held in format bits 1:0
`define SSP_FRAME_2STOP_NOPAR 2'h0
`define SSP_FRAME_1STOP_NOPAR 2'h1
`define SSP_FRAME_1STOP_EVEN 2'h2
`define SSP_FRAME_1STOP_ODD 2'h3

// reset values
`define SSP_FMT_RST 4'h0
`define SSP_BAUD_RST 4'h6
`define SSP_ADDR_RST 8'h01

// legal ranges
`define SSP_BAUD_MAX 4'h9
`define SSP_ADDR_MIN 8'h01
`define SSP_ADDR_MAX 8'hf7
`define SSP_ADDR_BCAST 8'h00

// register numbering schemes
`define SSP_STD_MULT 17'h00064
`define SSP_STD_MENU_MAX 8'ha2
`define SSP_STD_PARAM_MAX 8'h63
`define SSP_MOD_MENU_MAX 8'h3f
`define SSP_MOD_PARAM_MAX 8'hff

// local write selector codes
`define SSP_SEL_FORMAT 2'h0
`define SSP_SEL_BAUD 2'h1
`define SSP_SEL_ADDR 2'h2

// configuration parameters reachable over the link
`define SSP_CFG_MENU 8'h0b
`define SSP_PAR_ADDR 8'h17
`define SSP_PAR_FORMAT 8'h18
`define SSP_PAR_BAUD 8'h19

`endif

// ===== core/ssp_reg_decode.v
`timescale 1ns/10ps
`include "ssp_regs.vh"

module ssp_reg_decode (
    input wire modified_i,
    input wire [15:0] reg_addr_i,
    output reg [7:0] menu_number_o,
    output reg [7:0] param_o,
    output reg valid_o
);

    reg [16:0] addr_p1;
    reg [16:0] quot;
    reg [16:0] rem;

    always @* begin
        addr_p1 = {1'b0, reg_addr_i} + 17'h00001;
        quot = 17'h00000;
        rem = 17'h00000;
        menu_number_o = 8'h00;
        param_o = 8'h00;
        valid_o = 1'b0;
        if (modified_i) begin
            // menu*256 + param - 1
            menu_number_o = addr_p1[15:8];
            param_o = addr_p1[7:0];
            valid_o = (addr_p1[16] == 1'b0) && (addr_p1[15:8] <= `SSP_MOD_MENU_MAX);
        end else begin
            // menu*100 + param - 1, menus above 162 cannot be named
            quot = addr_p1 / `SSP_STD_MULT;
            rem = addr_p1 % `SSP_STD_MULT;
            menu_number_o = quot[7:0];
            param_o = rem[7:0];
            valid_o = (quot <= {9'h000, `SSP_STD_MENU_MAX}) &&
                (rem <= {9'h000, `SSP_STD_PARAM_MAX});
        end
    end

endmodule

// ===== core/ssp_serial_cfg.v
// Function
// - the port only answers requests as a slave; it never starts a transfer.
// - format bits 1:0 pick stop bits and parity: 2N, 1N, 1E, 1O.
// - format bit 3 selects seven data bits; here it always reads zero.
// - format bit 2 picks standard or modified register numbering.
// - standard address is menu*100+param-1, menu up to 162, param up to 99.
// - modified address is menu*256+param-1, menu up to 63, param up to 255.
// - params above 99 in menus above 63 stay unreachable in both schemes.
// - new format or baud takes effect only on a comms reset action.
// - reply to a link format change goes out in the old framing.
// - reply to a link baud change uses old rate; master then waits 20 ms.
// - own address stays within 1 to 247; address 0 is broadcast.
// - rtu framing is eight data bits; seven-bit framing is not offered.
// - format writable from keypad, option module or the link itself.
`timescale 1ns/10ps
`include "ssp_regs.vh"

module ssp_serial_cfg (
    input wire SYS_CLK_I,
    input wire RST_I,
    input wire KP_WE_I,
    input wire [1:0] KP_SEL_I,
    input wire [7:0] KP_WDATA_I,
    input wire OPT_WE_I,
    input wire [1:0] OPT_SEL_I,
    input wire [7:0] OPT_WDATA_I,
    input wire COMMS_RESET_I,
    input wire REQ_VALID_I,
    input wire [7:0] REQ_SLAVE_I,
    input wire [15:0] REQ_REG_ADDR_I,
    input wire REQ_WRITE_I,
    input wire [15:0] REQ_WDATA_I,
    output reg [3:0] CFG_FORMAT_O,
    output reg [3:0] CFG_BAUD_O,
    output reg [7:0] CFG_ADDR_O,
    output reg ACT_STOP2_O,
    output reg ACT_PARITY_EN_O,
    output reg ACT_PARITY_ODD_O,
    output reg ACT_DATA7_O,
    output reg ACT_MODIFIED_O,
    output reg [3:0] ACT_BAUD_O,
    output reg REQ_ACCEPT_O,
    output reg REQ_BROADCAST_O,
    output reg REPLY_EN_O,
    output reg REQ_REG_OK_O,
    output reg [7:0] REQ_MENU_O,
    output reg [7:0] REQ_PARAM_O,
    output reg CFG_WRITE_REJ_O
);

    // framing fields out of a format code
    function [2:0] frame_bits;
        input [1:0] code;
        begin
            case (code)
                `SSP_FRAME_2STOP_NOPAR: frame_bits = 3'b100;
                `SSP_FRAME_1STOP_NOPAR: frame_bits = 3'b000;
                `SSP_FRAME_1STOP_EVEN: frame_bits = 3'b010;
                `SSP_FRAME_1STOP_ODD: frame_bits = 3'b011;
                default: frame_bits = 3'b100;
            endcase
        end
    endfunction

    // legality of a configuration write
    function write_ok;
        input [1:0] sel;
        input [7:0] data;
        begin
            case (sel)
                `SSP_SEL_FORMAT: write_ok = 1'b1;
                `SSP_SEL_BAUD: write_ok = (data <= {4'h0, `SSP_BAUD_MAX});
                `SSP_SEL_ADDR: write_ok = (data >= `SSP_ADDR_MIN) &&
                    (data <= `SSP_ADDR_MAX);
                default: write_ok = 1'b0;
            endcase
        end
    endfunction

    reg [3:0] fmt_q;
    reg [3:0] fmt_d;
    reg [3:0] baud_q;
    reg [3:0] baud_d;
    reg [7:0] addr_q;
    reg [7:0] addr_d;
    reg [3:0] act_fmt_q;
    reg [3:0] act_baud_q;
    reg rej_d;

    wire [7:0] dec_menu;
    wire [7:0] dec_param;
    wire dec_valid;

    // numbering follows the active scheme, not the pending one
    ssp_reg_decode u_dec (
        .modified_i(act_fmt_q[`SSP_FMT_REGMODE_BIT]),
        .reg_addr_i(REQ_REG_ADDR_I),
        .menu_number_o(dec_menu),
        .param_o(dec_param),
        .valid_o(dec_valid)
    );

    wire is_bcast = (REQ_SLAVE_I == `SSP_ADDR_BCAST);
    wire is_mine = (REQ_SLAVE_I == addr_q);
    wire hit = REQ_VALID_I && (is_bcast || is_mine);

    // link write onto one of the configuration parameters
    wire link_cfg = hit && REQ_WRITE_I && dec_valid && (dec_menu == `SSP_CFG_MENU);
    reg link_we;
    reg [1:0] link_sel;

    always @* begin
        link_we = 1'b0;
        link_sel = `SSP_SEL_FORMAT;
        if (link_cfg) begin
            case (dec_param)
                `SSP_PAR_FORMAT: begin
                    link_we = 1'b1;
                    link_sel = `SSP_SEL_FORMAT;
                end
                `SSP_PAR_BAUD: begin
                    link_we = 1'b1;
                    link_sel = `SSP_SEL_BAUD;
                end
                `SSP_PAR_ADDR: begin
                    link_we = 1'b1;
                    link_sel = `SSP_SEL_ADDR;
                end
                default: begin
                    link_we = 1'b0;
                    link_sel = `SSP_SEL_FORMAT;
                end
            endcase
        end
    end

    // keypad first, then option module, then link; one write per cycle
    reg any_we;
    reg [1:0] w_sel;
    reg [7:0] w_data;

    always @* begin
        any_we = 1'b0;
        w_sel = `SSP_SEL_FORMAT;
        w_data = 8'h00;
        if (KP_WE_I) begin
            any_we = 1'b1;
            w_sel = KP_SEL_I;
            w_data = KP_WDATA_I;
        end else if (OPT_WE_I) begin
            any_we = 1'b1;
            w_sel = OPT_SEL_I;
            w_data = OPT_WDATA_I;
        end else if (link_we) begin
            any_we = 1'b1;
            w_sel = link_sel;
            w_data = REQ_WDATA_I[7:0];
        end
    end

    always @* begin
        fmt_d = fmt_q;
        baud_d = baud_q;
        addr_d = addr_q;
        rej_d = 1'b0;
        if (any_we) begin
            if (!write_ok(w_sel, w_data)) begin
                rej_d = 1'b1;
            end else begin
                case (w_sel)
                    `SSP_SEL_FORMAT: begin
                        // seven-bit framing is never stored
                        fmt_d = {1'b0, w_data[2:0]};
                    end
                    `SSP_SEL_BAUD: baud_d = w_data[3:0];
                    `SSP_SEL_ADDR: addr_d = w_data;
                    default: fmt_d = fmt_q;
                endcase
            end
        end
    end

    always @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            fmt_q <= `SSP_FMT_RST;
            baud_q <= `SSP_BAUD_RST;
            addr_q <= `SSP_ADDR_RST;
            act_fmt_q <= `SSP_FMT_RST;
            act_baud_q <= `SSP_BAUD_RST;
        end else begin
            fmt_q <= fmt_d;
            baud_q <= baud_d;
            addr_q <= addr_d;
            // live settings move only on the explicit reset action, so a reply
            // to the changing request still leaves in the old format and rate
            if (COMMS_RESET_I) begin
                act_fmt_q <= fmt_q;
                act_baud_q <= baud_q;
            end
        end
    end

    // outputs, all registered
    always @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            CFG_FORMAT_O <= `SSP_FMT_RST;
            CFG_BAUD_O <= `SSP_BAUD_RST;
            CFG_ADDR_O <= `SSP_ADDR_RST;
            ACT_STOP2_O <= 1'b1;
            ACT_PARITY_EN_O <= 1'b0;
            ACT_PARITY_ODD_O <= 1'b0;
            ACT_DATA7_O <= 1'b0;
            ACT_MODIFIED_O <= 1'b0;
            ACT_BAUD_O <= `SSP_BAUD_RST;
            REQ_ACCEPT_O <= 1'b0;
            REQ_BROADCAST_O <= 1'b0;
            REPLY_EN_O <= 1'b0;
            REQ_REG_OK_O <= 1'b0;
            REQ_MENU_O <= 8'h00;
            REQ_PARAM_O <= 8'h00;
            CFG_WRITE_REJ_O <= 1'b0;
        end else begin
            CFG_FORMAT_O <= fmt_d;
            CFG_BAUD_O <= baud_d;
            CFG_ADDR_O <= addr_d;
            {ACT_STOP2_O, ACT_PARITY_EN_O, ACT_PARITY_ODD_O} <=
                frame_bits(act_fmt_q[`SSP_FMT_FRAME_MSB:`SSP_FMT_FRAME_LSB]);
            ACT_DATA7_O <= act_fmt_q[`SSP_FMT_DATA7_BIT];
            ACT_MODIFIED_O <= act_fmt_q[`SSP_FMT_REGMODE_BIT];
            ACT_BAUD_O <= act_baud_q;
            REQ_ACCEPT_O <= hit;
            REQ_BROADCAST_O <= hit && is_bcast;
            // a reply exists only as the answer to a unicast request
            REPLY_EN_O <= hit && is_mine && !is_bcast;
            REQ_REG_OK_O <= hit && dec_valid;
            REQ_MENU_O <= hit ? dec_menu : 8'h00;
            REQ_PARAM_O <= hit ? dec_param : 8'h00;
            CFG_WRITE_REJ_O <= rej_d;
        end
    end

endmodule

// ===== verif/ssp_cfg_chk_asserts.sv
`timescale 1ns/10ps
module ssp_cfg_chk (
    input wire SYS_CLK_I,
    input wire RST_I,
    input wire KP_WE_I,
    input wire [1:0] KP_SEL_I,
    input wire [7:0] KP_WDATA_I,
    input wire COMMS_RESET_I,
    input wire REQ_VALID_I,
    input wire [7:0] REQ_SLAVE_I,
    input wire [3:0] CFG_FORMAT_O,
    input wire [3:0] CFG_BAUD_O,
    input wire [7:0] CFG_ADDR_O,
    input wire ACT_STOP2_O,
    input wire ACT_PARITY_EN_O,
    input wire ACT_PARITY_ODD_O,
    input wire ACT_DATA7_O,
    input wire ACT_MODIFIED_O,
    input wire [3:0] ACT_BAUD_O,
    input wire REQ_ACCEPT_O,
    input wire REQ_BROADCAST_O,
    input wire REPLY_EN_O,
    input wire REQ_REG_OK_O,
    input wire [7:0] REQ_MENU_O,
    input wire [7:0] REQ_PARAM_O,
    input wire CFG_WRITE_REJ_O
);
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (RST_I);
    reg [7:0] cap_q;
    wire [8:0] act_w;
    assign act_w = {ACT_STOP2_O, ACT_PARITY_EN_O, ACT_PARITY_ODD_O, ACT_MODIFIED_O,
        ACT_DATA7_O, ACT_BAUD_O};
    // pending values as seen at the apply pulse
    always @(posedge SYS_CLK_I) begin
        if (COMMS_RESET_I) cap_q <= {CFG_FORMAT_O, CFG_BAUD_O};
    end
    property p_fmt8; !CFG_FORMAT_O[3] && !ACT_DATA7_O; endproperty
    a_fmt8: assert property (p_fmt8) else $error("seven bit");
    property p_hold; (!COMMS_RESET_I)[*3] |=> $stable(act_w); endproperty
    a_hold: assert property (p_hold) else $error("early apply");
    property p_apply; COMMS_RESET_I ##1 (!COMMS_RESET_I)[*2] |=> act_w == {cap_q[5:4] == 2'h0,
        cap_q[5], cap_q[5:4] == 2'h3, cap_q[6], 1'b0, cap_q[3:0]}; endproperty
    a_apply: assert property (p_apply) else $error("bad apply");
    property p_foreign; REQ_VALID_I && REQ_SLAVE_I != CFG_ADDR_O && REQ_SLAVE_I != 8'h00
        |=> !REQ_ACCEPT_O && !REPLY_EN_O && !REQ_REG_OK_O; endproperty
    a_foreign: assert property (p_foreign) else $error("foreign taken");
    property p_own; REQ_VALID_I && REQ_SLAVE_I == CFG_ADDR_O
        |=> REQ_ACCEPT_O && REPLY_EN_O && !REQ_BROADCAST_O; endproperty
    a_own: assert property (p_own) else $error("own missed");
    property p_bcast; REQ_VALID_I && REQ_SLAVE_I == 8'h00
        |=> REQ_ACCEPT_O && REQ_BROADCAST_O && !REPLY_EN_O; endproperty
    a_bcast: assert property (p_bcast) else $error("bcast");
    property p_rej; KP_WE_I && KP_SEL_I == 2'h2 && (KP_WDATA_I == 8'h00 || KP_WDATA_I > 8'hf7)
        |=> CFG_WRITE_REJ_O && $stable(CFG_ADDR_O); endproperty
    a_rej: assert property (p_rej) else $error("bad addr kept");
    // the decode and ACT_MODIFIED_O are loaded at one edge, so no $past here
    property p_std; REQ_REG_OK_O && !ACT_MODIFIED_O
        |-> REQ_MENU_O <= 8'ha2 && REQ_PARAM_O <= 8'h63; endproperty
    a_std: assert property (p_std) else $error("std range");
    property p_mod; REQ_REG_OK_O && ACT_MODIFIED_O |-> REQ_MENU_O <= 8'h3f; endproperty
    a_mod: assert property (p_mod) else $error("mod range");
endmodule

bind ssp_serial_cfg ssp_cfg_chk u_chk (.*);

// ===== verif/ssp_master_model.sv
`timescale 1ns/10ps
module ssp_master_model (
    input wire clk_i,
    output reg valid_o,
    output reg [7:0] slave_o,
    output reg [15:0] addr_o,
    output reg write_o,
    output reg [15:0] wdata_o
);
    initial {valid_o, slave_o, addr_o, write_o, wdata_o} = 42'h0;
    task send(input [7:0] s, input [15:0] a, input w, input [15:0] d);
        begin
            @(negedge clk_i);
            {valid_o, slave_o, addr_o, write_o, wdata_o} = {1'b1, s, a, w, d};
            @(negedge clk_i);
            // released lines flip so a stale header never passes
            {valid_o, slave_o, addr_o, write_o, wdata_o} = {1'b0, ~s, ~a, 1'b0, ~d};
        end
    endtask
    // wait scaled down, the device does not time it
    task settle(input integer n);
        repeat (n) @(negedge clk_i);
    endtask
endmodule

// ===== verif/serial_slave_port_config_tb.sv
`timescale 1ns/10ps
module serial_slave_port_config_tb;
    reg SYS_CLK_I = 1'b0;
    reg RST_I = 1'b1;
    reg KP_WE_I = 1'b0;
    reg OPT_WE_I = 1'b0;
    reg COMMS_RESET_I = 1'b0;
    reg [1:0] KP_SEL_I = 2'h0;
    reg [1:0] OPT_SEL_I = 2'h0;
    reg [7:0] KP_WDATA_I = 8'h00;
    reg [7:0] OPT_WDATA_I = 8'h00;
    wire REQ_VALID_I, REQ_WRITE_I, ACT_STOP2_O, ACT_PARITY_EN_O, ACT_PARITY_ODD_O;
    wire ACT_DATA7_O, ACT_MODIFIED_O, REQ_ACCEPT_O, REQ_BROADCAST_O, REPLY_EN_O;
    wire REQ_REG_OK_O, CFG_WRITE_REJ_O;
    wire [3:0] CFG_FORMAT_O, CFG_BAUD_O, ACT_BAUD_O;
    wire [7:0] REQ_SLAVE_I, CFG_ADDR_O, REQ_MENU_O, REQ_PARAM_O;
    wire [15:0] REQ_REG_ADDR_I, REQ_WDATA_I;
    integer error_cnt = 0, check_count = 0, fmt = 0, baud = 6, addr = 1, af = 0, ab = 6, i;
    always #4 SYS_CLK_I = ~SYS_CLK_I;
    ssp_serial_cfg DUT (.*);
    ssp_master_model u_mst (.clk_i(SYS_CLK_I), .valid_o(REQ_VALID_I), .slave_o(REQ_SLAVE_I),
        .addr_o(REQ_REG_ADDR_I), .write_o(REQ_WRITE_I), .wdata_o(REQ_WDATA_I));
    task ck(input [31:0] got, input [31:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task give_verdict;
        begin
            $display("checks %0d errors %0d", check_count, error_cnt);
            if (error_cnt == 0 && check_count > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    task cfgck;
        ck({CFG_FORMAT_O, CFG_BAUD_O, CFG_ADDR_O}, {fmt[3:0], baud[3:0], addr[7:0]});
    endtask
    task actck;
        ck({ACT_STOP2_O, ACT_PARITY_EN_O, ACT_PARITY_ODD_O, ACT_MODIFIED_O, ACT_DATA7_O,
            ACT_BAUD_O}, {af[1:0] == 0, af[1], af[1:0] == 3, af[2], 1'b0, ab[3:0]});
    endtask
    task wm(input [1:0] s, input [7:0] d);
        begin
            if (s == 0) fmt = d[2:0];
            if (s == 1 && d <= 9) baud = d;
            if (s == 2 && d >= 1 && d <= 247) addr = d;
        end
    endtask
    task kw(input o, input [1:0] s, input [7:0] d);
        begin
            @(negedge SYS_CLK_I);
            {KP_WE_I, OPT_WE_I} = {~o, o};
            {KP_SEL_I, OPT_SEL_I, KP_WDATA_I, OPT_WDATA_I} = {s, s, d, d};
            @(negedge SYS_CLK_I);
            {KP_WE_I, OPT_WE_I} = 2'b00;
            ck(CFG_WRITE_REJ_O, s == 1 && d > 9 || s == 2 && (d == 0 || d > 247));
            wm(s, d);
            cfgck;
            actck;
        end
    endtask
    task creset;
        begin
            @(negedge SYS_CLK_I);
            COMMS_RESET_I = 1'b1;
            @(negedge SYS_CLK_I);
            COMMS_RESET_I = 1'b0;
            repeat (2) @(negedge SYS_CLK_I);
            af = fmt;
            ab = baud;
            actck;
        end
    endtask
    task req(input [7:0] s, input [15:0] a, input w, input [7:0] d);
        integer m, p, hit, ok;
        begin
            hit = s == addr || s == 0;
            m = af[2] ? (a + 1) / 256 : (a + 1) / 100;
            p = af[2] ? (a + 1) % 256 : (a + 1) % 100;
            ok = hit && m <= (af[2] ? 63 : 162);
            u_mst.send(s, a, w, {8'h00, d});
            ck({REQ_ACCEPT_O, REPLY_EN_O, REQ_BROADCAST_O}, {hit[0], hit && s != 0, s == 0});
            ck(REQ_REG_OK_O, ok);
            if (ok) ck({REQ_MENU_O, REQ_PARAM_O}, {m[7:0], p[7:0]});
            if (ok && w && m == 11 && p >= 23 && p <= 25) wm(p % 3, d);
            cfgck;
            actck;
        end
    endtask
    initial begin
        i = $urandom(14);
        repeat (3) @(negedge SYS_CLK_I);
        RST_I = 1'b0;
        cfgck;
        actck;
        for (i = 0; i < 8; i = i + 1) begin
            kw(i[0], 0, 8'h08 | i);
            kw(~i[0], 1, i + 3);
            creset;
        end
        kw(0, 2, 8'h00);
        kw(1, 2, 8'hf8);
        kw(0, 2, $urandom % 247 + 1);
        for (i = 0; i < 60; i = i + 1) begin
            if (i == 30) begin
                kw(0, 0, 8'h01);
                creset;
            end
            req(i[0] ? addr : $urandom, $urandom & 16'h7ffe, 0, 0);
        end
        req(addr, 1123, 1, 5);
        req(0, 1124, 1, 2);
        u_mst.settle(8);
        creset;
        req(addr, 1536, 0, 0);
        give_verdict;
    end
    initial begin
        #100000;
        error_cnt = error_cnt + 1;
        give_verdict;
    end
endmodule
